// >>> shared/uhfd_map.svh
/*
   offsets, field positions, reset values and timing counts of the
   frame interval / done queue block; assumes byte addressing on a 32-bit bus.
*/
// How it works
// R1: when a transfer descriptor completes, the current done queue head goes into its link field.
// R2: then the head takes the completed descriptor address in bits 31 to 4.
// R3: each copy of the head out to the host communication area clears the head to zero; a completion in the same cycle loads the head instead.
// R4: the head is copied out to the host communication area once per frame, at frame start.
// R5: a 14-bit frame interval in bits 13 to 0 sets the bit times between frame starts.
// R6: reset puts the frame interval back to its nominal 11,999 (0x2EDF).
// R7: software saves the interval before a controller reset and may write it back later.
// R8: software may trim the interval at each frame start by rewriting the field.
// R9: software inverts the toggle bit 31 whenever it loads a new interval.
// R10: at each frame start the 15-bit budget in bits 30 to 16 loads the packet counter.
// R11: the packet counter is the most bits one transaction may move without overrun.
// R12: software computes the budget value; the block never derives it.
// R13: the counter falls per bit time and no transaction larger than what is left starts.
`ifndef UHFD_MAP_SVH
`define UHFD_MAP_SVH
`define UHFD_OFS_DONE_HEAD   8'h30
`define UHFD_OFS_FRAME_INT   8'h34
`define UHFD_IVL_RESET       14'h2EDF
`define UHFD_IVL_LSB         0
`define UHFD_IVL_MSB         13
`define UHFD_LP_LSB          16
`define UHFD_LP_MSB          30
`define UHFD_TGL_BIT         31
`define UHFD_HEAD_LSB        4
`define UHFD_CLK_HZ          40000000
`define UHFD_BIT_HZ          12000000
`endif

// >>> shared/uhfd_pkg.sv
/*
   types of the frame interval / done queue block; assumes uhfd_map.svh alongside.
*/
package uhfd_pkg;
   typedef enum logic [1:0] {
      UHFD_OKAY   = 2'b00,
      UHFD_SLVERR = 2'b10
   } uhfd_resp_t;
endpackage

// >>> hdl/uhfd_top.sv
/*
   done queue head and frame interval registers with the frame timer and
   largest packet budget counter behind them, on an AXI4-Lite slave.
   assumes bit_tick is a one-cycle enable per full-speed bit time from a divider
   on aclk, and that desc_done, desc_addr, tx_req and tx_bits are driven on aclk.
*/
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "uhfd_map.svh"
module uhfd_top
   import uhfd_pkg::*;
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        bit_tick,
   input  wire logic        desc_done,
   input  wire logic [31:0] desc_addr,
   output logic             link_wr_valid,
   output logic [31:0]      link_wr_addr,
   output logic [31:0]      link_wr_data,
   output logic             area_wr_valid,
   output logic [31:0]      area_wr_data,
   output logic             frame_start,
   input  wire logic        tx_req,
   input  wire logic [14:0] tx_bits,
   output logic             tx_grant,
   output logic [14:0]      budget_left
);
   function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0]  strb);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (strb[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   // bus state
   logic              aw_have_q, aw_have_d, w_have_q, w_have_d;
   logic [7:0]        aw_addr_q, aw_addr_d;
   logic [31:0]       w_data_q, w_data_d;
   logic [3:0]        w_strb_q, w_strb_d;
   logic              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
   uhfd_resp_t        bresp_q, bresp_d, rresp_q, rresp_d;
   logic [31:0]       rdata_q, rdata_d;
   // register and timing state
   logic [27:0]       head_q, head_d;
   logic [13:0]       ivl_q, ivl_d;
   logic [14:0]       lpb_q, lpb_d;
   logic              tgl_q, tgl_d;
   logic [13:0]       fcnt_q, fcnt_d;
   logic [14:0]       lp_q, lp_d;
   logic              lwv_q, lwv_d, hwv_q, hwv_d, sof_q, sof_d, grant_q, grant_d;
   logic [31:0]       lwa_q, lwa_d, lwd_q, lwd_d, hwd_q, hwd_d;
   logic              do_write, sof_evt;
   logic [31:0]       ivl_word, head_word, wr_val;
   logic              awrdy_q, awrdy_d, wrdy_q, wrdy_d, arrdy_q, arrdy_d;

   assign ivl_word  = {tgl_q, lpb_q, 2'b00, ivl_q};
   assign head_word = {head_q, 4'h0};
   assign do_write = aw_have_q && w_have_q && !bvalid_q;
   assign sof_evt = bit_tick && (fcnt_q == 14'h0000);

   always_comb begin
      aw_have_d = aw_have_q;
      w_have_d  = w_have_q;
      aw_addr_d = aw_addr_q;
      w_data_d  = w_data_q;
      w_strb_d  = w_strb_q;
      bvalid_d  = bvalid_q;
      bresp_d   = bresp_q;
      rvalid_d  = rvalid_q;
      rresp_d   = rresp_q;
      rdata_d   = rdata_q;
      if (s_axi_awvalid && s_axi_awready) begin
         aw_have_d = 1'b1;
         aw_addr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
         w_have_d = 1'b1;
         w_data_d = s_axi_wdata;
         w_strb_d = s_axi_wstrb;
      end
      if (do_write) begin
         aw_have_d = 1'b0;
         w_have_d  = 1'b0;
         bvalid_d  = 1'b1;
         bresp_d   = (aw_addr_q == `UHFD_OFS_DONE_HEAD || aw_addr_q == `UHFD_OFS_FRAME_INT)
                     ? UHFD_OKAY : UHFD_SLVERR;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_d = 1'b1;
         rresp_d  = UHFD_OKAY;
         unique case (s_axi_araddr)
            `UHFD_OFS_DONE_HEAD: rdata_d = head_word;
            `UHFD_OFS_FRAME_INT: rdata_d = ivl_word;
            default: begin
               rdata_d = 32'h0000_0000;
               rresp_d = UHFD_SLVERR;
            end
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
      // readies register the next held flags, so the ports stay flop-driven
      awrdy_d = !aw_have_d && !bvalid_d;
      wrdy_d  = !w_have_d && !bvalid_d;
      arrdy_d = !rvalid_d;
   end

   always_comb begin
      ivl_d   = ivl_q;
      lpb_d   = lpb_q;
      tgl_d   = tgl_q;
      head_d  = head_q;
      wr_val  = 32'h0000_0000;
      if (do_write && aw_addr_q == `UHFD_OFS_FRAME_INT) begin
         // interval trims take effect at the next reload, so a frame never shortens mid-count
         wr_val  = strb_merge(ivl_word, w_data_q, w_strb_q);
         ivl_d   = wr_val[`UHFD_IVL_MSB:`UHFD_IVL_LSB];
         lpb_d   = wr_val[`UHFD_LP_MSB:`UHFD_LP_LSB];
         tgl_d   = wr_val[`UHFD_TGL_BIT];
      end
      if (do_write && aw_addr_q == `UHFD_OFS_DONE_HEAD) begin
         wr_val = strb_merge(head_word, w_data_q, w_strb_q);
         head_d = wr_val[31:`UHFD_HEAD_LSB];
      end
      if (sof_evt) begin
         head_d = 28'h000_0000; // see R3
      end
      // a completion wins over both the clear and a software write
      if (desc_done) begin
         head_d = desc_addr[31:`UHFD_HEAD_LSB]; // see R2
      end
   end

   always_comb begin
      fcnt_d  = fcnt_q;
      lp_d    = lp_q;
      sof_d   = sof_evt;
      lwv_d   = desc_done;
      lwa_d   = desc_done ? {desc_addr[31:`UHFD_HEAD_LSB], 4'h0} : lwa_q;
      lwd_d   = desc_done ? head_word : lwd_q; // see R1
      hwv_d   = sof_evt; // see R4
      hwd_d   = sof_evt ? head_word : hwd_q;
      grant_d = tx_req && (tx_bits <= lp_q); // see R11
      if (sof_evt) begin
         fcnt_d = ivl_q; // see R5
         lp_d   = lpb_q; // see R10
      end else if (bit_tick) begin
         fcnt_d = fcnt_q - 14'h0001;
         if (lp_q != 15'h0000) begin
            lp_d = lp_q - 15'h0001; // see R13
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q  <= 1'b0;
         aw_addr_q <= 8'h00;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         bvalid_q  <= 1'b0;
         bresp_q   <= UHFD_OKAY;
         rvalid_q  <= 1'b0;
         rresp_q   <= UHFD_OKAY;
         rdata_q   <= 32'h0000_0000;
         head_q    <= 28'h000_0000;
         ivl_q     <= `UHFD_IVL_RESET; // see R6
         lpb_q     <= 15'h0000;
         tgl_q     <= 1'b0;
         fcnt_q    <= `UHFD_IVL_RESET;
         lp_q      <= 15'h0000;
         sof_q     <= 1'b0;
         lwv_q     <= 1'b0;
         lwa_q     <= 32'h0000_0000;
         lwd_q     <= 32'h0000_0000;
         hwv_q     <= 1'b0;
         hwd_q     <= 32'h0000_0000;
         grant_q   <= 1'b0;
         awrdy_q   <= 1'b1;
         wrdy_q    <= 1'b1;
         arrdy_q   <= 1'b1;
      end else begin
         aw_have_q <= aw_have_d;
         w_have_q  <= w_have_d;
         aw_addr_q <= aw_addr_d;
         w_data_q  <= w_data_d;
         w_strb_q  <= w_strb_d;
         bvalid_q  <= bvalid_d;
         bresp_q   <= bresp_d;
         rvalid_q  <= rvalid_d;
         rresp_q   <= rresp_d;
         rdata_q   <= rdata_d;
         head_q    <= head_d;
         ivl_q     <= ivl_d;
         lpb_q     <= lpb_d;
         tgl_q     <= tgl_d;
         fcnt_q    <= fcnt_d;
         lp_q      <= lp_d;
         sof_q     <= sof_d;
         lwv_q     <= lwv_d;
         lwa_q     <= lwa_d;
         lwd_q     <= lwd_d;
         hwv_q     <= hwv_d;
         hwd_q     <= hwd_d;
         grant_q   <= grant_d;
         awrdy_q   <= awrdy_d;
         wrdy_q    <= wrdy_d;
         arrdy_q   <= arrdy_d;
      end
   end

   assign s_axi_awready = awrdy_q;
   assign s_axi_wready  = wrdy_q;
   assign s_axi_arready = arrdy_q;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;
   assign link_wr_valid = lwv_q;
   assign link_wr_addr  = lwa_q;
   assign link_wr_data  = lwd_q;
   assign area_wr_valid = hwv_q;
   assign area_wr_data  = hwd_q;
   assign frame_start   = sof_q;
   assign tx_grant      = grant_q;
   assign budget_left   = lp_q;

   sequence s_frame_edge;
      bit_tick && (fcnt_q == 14'h0000);
   endsequence

   a_link_old_head: assert property (@(posedge aclk) disable iff (!aresetn) // see R1
      desc_done |=> link_wr_valid && link_wr_data == $past(head_word))
      else $error("link field did not get the old head");
   a_head_takes_desc: assert property (@(posedge aclk) disable iff (!aresetn) // see R2
      desc_done |=> head_q == $past(desc_addr[31:4]))
      else $error("head did not take the completed descriptor");
   a_copy_clears_head: assert property (@(posedge aclk) disable iff (!aresetn) // see R3
      s_frame_edge ##0 !desc_done |=> area_wr_valid && head_q == 28'h000_0000)
      else $error("head not cleared after copy out");
   a_copy_per_frame: assert property (@(posedge aclk) disable iff (!aresetn) // see R4
      s_frame_edge |=> area_wr_valid && frame_start && area_wr_data == $past(head_word))
      else $error("head not copied at frame start");
   a_interval_reload: assert property (@(posedge aclk) disable iff (!aresetn) // see R5
      s_frame_edge |=> fcnt_q == $past(ivl_q))
      else $error("frame counter not reloaded from interval");
   a_interval_reset: assert property (@(posedge aclk) // see R6
      !aresetn |=> ivl_q == `UHFD_IVL_RESET)
      else $error("interval not nominal after reset");
   a_budget_load: assert property (@(posedge aclk) disable iff (!aresetn) // see R10
      s_frame_edge |=> budget_left == $past(lpb_q))
      else $error("budget counter not loaded at frame start");
   a_grant_limit: assert property (@(posedge aclk) disable iff (!aresetn) // see R11
      tx_grant |-> $past(tx_req) && $past(tx_bits) <= $past(lp_q))
      else $error("grant beyond remaining budget");
   a_budget_falls: assert property (@(posedge aclk) disable iff (!aresetn) // see R13
      bit_tick && !(fcnt_q == 14'h0000) && lp_q != 15'h0000 |=> lp_q == $past(lp_q) - 15'h0001)
      else $error("budget did not fall by one bit time");
endmodule

// >>> bench/uhfd_mem_model.sv
/*
   system memory sink: keeps the last descriptor link write and the last
   communication area write; assumes one-cycle write pulses on aclk.
*/
`timescale 1ns/1ps
module uhfd_mem_model (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        link_wr_valid,
   input  wire logic [31:0] link_wr_addr,
   input  wire logic [31:0] link_wr_data,
   input  wire logic        area_wr_valid,
   input  wire logic [31:0] area_wr_data,
   output logic [31:0]      last_link_addr,
   output logic [31:0]      last_link_data,
   output logic [31:0]      last_area,
   output logic [31:0]      n_links
);
   // memory takes every write at once; no back-pressure exists on this side
   always @(posedge aclk) begin
      if (!aresetn) begin
         last_link_addr <= 32'h0000_0000;
         last_link_data <= 32'h0000_0000;
         last_area      <= 32'h0000_0000;
         n_links        <= 32'h0000_0000;
      end else begin
         if (link_wr_valid) begin
            last_link_addr <= link_wr_addr;
            last_link_data <= link_wr_data;
            n_links        <= n_links + 32'h0000_0001;
         end
         if (area_wr_valid) begin
            last_area <= area_wr_data;
         end
      end
   end
endmodule

// >>> bench/usb_host_frame_interval_done_queue_tb.sv
/*
   self-checking bench: axi4-lite master tasks, descriptor completions,
   frame timing and grants; assumes bit_tick may pulse every cycle.
*/
`timescale 1ns/1ps
module usb_host_frame_interval_done_queue_tb;
   import uhfd_pkg::*;
   logic        aclk = 0, aresetn = 0, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
   logic        s_axi_arvalid, s_axi_rready, bit_tick, desc_done, tx_req;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, desc_addr, s_axi_rdata, link_wr_addr, link_wr_data, area_wr_data;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic        link_wr_valid, area_wr_valid, frame_start, tx_grant;
   logic [14:0] tx_bits, budget_left, lp, lp2;
   logic [13:0] ivl, ivl2;
   logic [31:0] last_link_addr, last_link_data, last_area, n_links, n, ta[3];
   int          n_errors = 0, n_checks = 0, cyc = 0, seed = 32327;
   always #12.5 aclk = ~aclk;
   uhfd_top DUT (.*);
   uhfd_mem_model mem (.*);
   function automatic logic [31:0] ivl_word(logic t, logic [14:0] b, logic [13:0] f);
      return {t, b, 2'b00, f};
   endfunction
   function automatic logic [31:0] link_addr(logic [31:0] a);
      return {a[31:4], 4'h0};
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("mismatch at %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1;
      s_axi_wdata <= d;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wready) s_axi_wvalid <= 0;
      end while (!s_axi_bvalid);
      s_axi_bready <= 0;
      chk(32'(s_axi_bresp), 32'(er));
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 0;
      end while (!s_axi_rvalid);
      s_axi_rready <= 0;
      chk(s_axi_rdata, ed);
      chk(32'(s_axi_rresp), 32'(er));
   endtask
   task automatic grant(input logic [14:0] b, input logic eg);
      @(posedge aclk);
      tx_req <= 1;
      tx_bits <= b;
      @(posedge aclk);
      tx_req <= 0;
      @(posedge aclk);
      chk(32'(tx_grant), 32'(eg));
   endtask
   // ticks every cycle; len is the tick count between two frame starts
   task automatic frame_len(output logic [31:0] len);
      bit_tick <= 1;
      do @(posedge aclk); while (!frame_start);
      len = 0;
      do begin
         @(posedge aclk);
         len++;
      end while (!frame_start);
      bit_tick <= 0;
   endtask
   task automatic test_done();
      $display("checks %0d mismatches %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   // a whole nominal frame is about 12000 cycles, so this leaves margin
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 16000) begin
         n_errors++;
         test_done();
      end
   end
   initial begin
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {bit_tick, desc_done, tx_req, s_axi_awaddr, s_axi_araddr, tx_bits} = '0;
      {s_axi_wdata, desc_addr} = '0;
      s_axi_wstrb = 4'hF;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(8'h34, 32'h0000_2EDF, 2'b00);
      rd(8'h30, 32'h0000_0000, 2'b00);
      rd(8'h40, 32'h0000_0000, 2'b10);
      wr(8'h40, 32'hFFFF_FFFF, 2'b10);
      lp = 15'($random(seed)) | 15'h0002;
      ivl = 14'h0004 + 14'($unsigned($random(seed)) % 8);
      wr(8'h34, ivl_word(1'b1, lp, ivl) | 32'h0000_C000, 2'b00);
      rd(8'h34, ivl_word(1'b1, lp, ivl), 2'b00);
      $display("test registers done");
      for (int i = 0; i < 3; i++) begin
         ta[i] = $random(seed);
         @(posedge aclk);
         desc_done <= 1;
         desc_addr <= ta[i];
      end
      @(posedge aclk);
      desc_done <= 0;
      repeat (3) @(posedge aclk);
      chk(n_links, 32'h0000_0003);
      chk(last_link_addr, link_addr(ta[2]));
      chk(last_link_data, link_addr(ta[1]));
      rd(8'h30, link_addr(ta[2]), 2'b00);
      $display("test completions done");
      frame_len(n);
      chk(n, 32'(ivl) + 1);
      chk(32'(budget_left), 32'(lp));
      chk(last_area, link_addr(ta[2]));
      @(posedge aclk);
      chk(32'(budget_left), 32'(lp) - 1);
      rd(8'h30, 32'h0000_0000, 2'b00);
      grant(lp - 15'h0001, 1'b1);
      grant(lp, 1'b0);
      $display("test frame done");
      // trim written in two byte-masked halves while the frame is under way
      lp2 = 15'($random(seed)) | 15'h0002;
      ivl2 = 14'h0004 + 14'($unsigned($random(seed)) % 8);
      s_axi_wstrb <= 4'h3;
      wr(8'h34, {18'h3_FFFF, ivl2}, 2'b00);
      s_axi_wstrb <= 4'hC;
      wr(8'h34, ivl_word(1'b0, lp2, 14'h3FFF), 2'b00);
      s_axi_wstrb <= 4'hF;
      rd(8'h34, ivl_word(1'b0, lp2, ivl2), 2'b00);
      ta[0] = $random(seed);
      @(posedge aclk);
      desc_done <= 1;
      desc_addr <= ta[0];
      @(posedge aclk);
      desc_done <= 0;
      frame_len(n);
      chk(n, 32'(ivl2) + 1);
      chk(32'(budget_left), 32'(lp2));
      chk(last_area, link_addr(ta[0]));
      chk(last_link_data, 32'h0000_0000);
      $display("test interval trim done");
      aresetn <= 0;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      rd(8'h34, 32'h0000_2EDF, 2'b00);
      wr(8'h34, ivl_word(1'b0, lp, ivl), 2'b00);
      rd(8'h34, ivl_word(1'b0, lp, ivl), 2'b00);
      $display("test restore done");
      test_done();
   end
endmodule
